// file: shared/rvs_pkg.sv
// Package with register map, field layout and carriers for the regulator select bank.
package rvs_pkg;

  // Printed offsets are not multiples of four, so they are register indices.
  localparam logic [7:0] IDX_LIN_A = 8'h2f;
  localparam logic [7:0] IDX_LIN_B = 8'h30;
  localparam logic [7:0] IDX_VIB = 8'h31;
  localparam logic [7:0] IDX_DVS_ONE = 8'h32;
  localparam logic [7:0] IDX_DVS_TWO = 8'h33;

  // Linear-regulator control fields.
  localparam int BIT_SEQ_TARGET = 7;
  localparam int POS_VGPIO = 5;
  localparam int BIT_VCHOICE = 4;
  localparam int BIT_PD_DIS = 3;
  localparam int POS_EGPIO = 1;
  localparam int BIT_ON = 0;

  // Reserved-bit masks of writable registers.
  localparam logic [7:0] MASK_VIB = 8'h3f;
  localparam logic [7:0] MASK_DVS_TWO = 8'h81;

  // Reset values.
  localparam logic [7:0] RST_LIN = 8'h00;
  localparam logic [7:0] RST_VIB = 8'h00;
  localparam logic [7:0] RST_DVS = 8'h00;

  // GPIO source encoding.
  localparam logic [1:0] SRC_SEQ = 2'h0;
  localparam logic [1:0] SRC_GPIO1 = 2'h1;
  localparam logic [1:0] SRC_GPIO2 = 2'h2;
  localparam logic [1:0] SRC_GENERAL_PIN_THIRTEEN = 2'h3;

  // Ramp timing: one step per ramp tick.
  localparam int RAMP_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RAMP_CYCLES = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_CNT_MAX = 8'(RAMP_CYCLES - 1);

  // Number of ramped supplies: 3 linear + 5 buck, then linear4 and io buck.
  localparam int NUM_RAMP = 10;

  // Per-regulator outputs of a linear-regulator control word.
  typedef struct packed {
    logic on;
    logic setting_second;
    logic pulldown_on;
  } rvs_lin_out_t;

  // Motor drive outputs.
  typedef struct packed {
    logic [5:0] level;
    logic brake;
    logic nmos_on;
    logic pmos_on;
  } rvs_motor_t;

endpackage

// file: hdl/rvs_regs.sv
// Regulator voltage-select register bank with APB slave and GPIO control.
`timescale 1ns/1ps
module rvs_regs
  import rvs_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sequencer and GPIO inputs.
  input wire logic seq_apply,
  input wire logic gpio_one,
  input wire logic gpio_two,
  input wire logic general_pin_thirteen,
  // Linear regulator controls.
  output rvs_lin_out_t reg_a_ctl,
  output rvs_lin_out_t reg_b_ctl,
  // Motor drive.
  output rvs_motor_t motor,
  // Ramped supplies: applied choice and busy request.
  output logic [NUM_RAMP-1:0] ramp_choice,
  output logic [NUM_RAMP-1:0] ramp_request
);

  // Selects a GPIO level by field code; code 00 yields no source.
  function automatic logic gpio_pick(input logic [1:0] src, input logic [2:0] pins);
    logic r;
    r = 1'b0;
    case (src)
      SRC_GPIO1: r = pins[0];
      SRC_GPIO2: r = pins[1];
      SRC_GENERAL_PIN_THIRTEEN: r = pins[2];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Applies sequencer and GPIO edges to one control word.
  function automatic logic [7:0] lin_update(input logic [7:0] w, input logic [2:0] now,
                                            input logic [2:0] last, input logic seq);
    logic [7:0] r;
    logic [1:0] vsrc;
    logic [1:0] esrc;
    r = w;
    vsrc = w[POS_VGPIO+:2];
    esrc = w[POS_EGPIO+:2];
    if (seq && esrc == SRC_SEQ) begin
      r[BIT_ON] = w[BIT_SEQ_TARGET];
    end
    if (vsrc != SRC_SEQ) begin
      if (gpio_pick(vsrc, now) && !gpio_pick(vsrc, last)) begin
        r[BIT_VCHOICE] = 1'b0;
      end else if (!gpio_pick(vsrc, now) && gpio_pick(vsrc, last)) begin
        r[BIT_VCHOICE] = 1'b1;
      end
    end
    if (esrc != SRC_SEQ) begin
      if (gpio_pick(esrc, now) && !gpio_pick(esrc, last)) begin
        r[BIT_ON] = 1'b1;
      end else if (!gpio_pick(esrc, now) && gpio_pick(esrc, last)) begin
        r[BIT_ON] = 1'b0;
      end
    end
    return r;
  endfunction

  // Derives regulator-side controls from a control word.
  function automatic rvs_lin_out_t lin_out(input logic [7:0] w);
    rvs_lin_out_t o;
    o.on = w[BIT_ON];
    o.setting_second = w[BIT_VCHOICE];
    o.pulldown_on = !w[BIT_ON] && !w[BIT_PD_DIS];
    return o;
  endfunction

  logic [7:0] lin_a_reg, lin_a_next;
  logic [7:0] lin_b_reg, lin_b_next;
  logic [7:0] vib_reg, vib_next;
  logic [7:0] dvs_one_reg, dvs_one_next;
  logic [7:0] dvs_two_reg, dvs_two_next;
  logic [2:0] pins_last_reg, pins_last_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  rvs_lin_out_t a_out_reg, a_out_next, b_out_reg, b_out_next;
  rvs_motor_t motor_reg, motor_next;
  logic [NUM_RAMP-1:0] applied_reg, applied_next;
  logic [NUM_RAMP-1:0] request_reg, request_next;
  logic [7:0] ramp_cnt_reg, ramp_cnt_next;
  logic [NUM_RAMP-1:0] target;
  logic [2:0] pins;
  logic [9:0] idx;
  logic hit, access, wr;

  assign pins = {general_pin_thirteen, gpio_two, gpio_one};
  assign idx = paddr[11:2];
  assign access = psel && penable && !pready_reg;
  assign wr = access && pwrite;
  assign target = {dvs_two_reg[7], dvs_two_reg[0], dvs_one_reg};

  // Register file, bus answer and edge tracking; one wait state per access.
  always_comb begin
    lin_a_next = lin_a_reg;
    lin_b_next = lin_b_reg;
    vib_next = vib_reg;
    dvs_one_next = dvs_one_reg;
    dvs_two_next = dvs_two_reg;
    prdata_next = prdata_reg;
    pready_next = access;
    pslverr_next = 1'b0;
    pins_last_next = pins;
    hit = paddr[1:0] == 2'h0 && (idx == 10'(IDX_LIN_A) || idx == 10'(IDX_LIN_B)
          || idx == 10'(IDX_VIB) || idx == 10'(IDX_DVS_ONE) || idx == 10'(IDX_DVS_TWO));
    lin_a_next = lin_update(lin_a_reg, pins, pins_last_reg, seq_apply);
    lin_b_next = lin_update(lin_b_reg, pins, pins_last_reg, seq_apply);
    // bus writes win over same-cycle hardware updates.
    if (wr && hit) begin
      case (idx[7:0])
        IDX_LIN_A: lin_a_next = pwdata[7:0];
        IDX_LIN_B: lin_b_next = pwdata[7:0];
        IDX_VIB: vib_next = pwdata[7:0] & MASK_VIB;
        IDX_DVS_ONE: dvs_one_next = pwdata[7:0];
        IDX_DVS_TWO: dvs_two_next = pwdata[7:0] & MASK_DVS_TWO;
        default: vib_next = vib_reg;
      endcase
    end
    if (access) begin
      pslverr_next = !hit;
      prdata_next = 32'h0;
      if (!pwrite && hit) begin
        case (idx[7:0])
          IDX_LIN_A: prdata_next = {24'h0, lin_a_reg};
          IDX_LIN_B: prdata_next = {24'h0, lin_b_reg};
          IDX_VIB: prdata_next = {24'h0, vib_reg};
          IDX_DVS_ONE: prdata_next = {24'h0, dvs_one_reg};
          IDX_DVS_TWO: prdata_next = {24'h0, dvs_two_reg};
          default: prdata_next = 32'h0;
        endcase
      end
    end
  end

  // Output decode of regulator and motor controls.
  always_comb begin
    a_out_next = lin_out(lin_a_next);
    b_out_next = lin_out(lin_b_next);
    motor_next.level = vib_next[5:0];
    motor_next.brake = vib_next[5:0] == 6'h00;
    motor_next.nmos_on = vib_next[5:0] == 6'h00;
    motor_next.pmos_on = 1'b0;
  end

  // Ramp sequencer: the applied choice moves after a ramp time; request stands meanwhile.
  always_comb begin
    applied_next = applied_reg;
    ramp_cnt_next = ramp_cnt_reg;
    request_next = target ^ applied_reg;
    if (request_reg == '0) begin
      ramp_cnt_next = 8'h00;
    end else if (request_next != request_reg) begin
      // A new change restarts the ramp, so no supply moves before its full ramp time.
      // Trade-off: supplies already ramping wait again when another one changes.
      ramp_cnt_next = 8'h00;
    end else if (ramp_cnt_reg == RAMP_CNT_MAX) begin
      ramp_cnt_next = 8'h00;
      applied_next = target;
      request_next = '0;
    end else begin
      ramp_cnt_next = ramp_cnt_reg + 8'h01;
    end
  end

  // State registers.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lin_a_reg <= RST_LIN;
      lin_b_reg <= RST_LIN;
      vib_reg <= RST_VIB;
      dvs_one_reg <= RST_DVS;
      dvs_two_reg <= RST_DVS;
      pins_last_reg <= 3'h0;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      a_out_reg <= '{on: 1'b0, setting_second: 1'b0, pulldown_on: 1'b1};
      b_out_reg <= '{on: 1'b0, setting_second: 1'b0, pulldown_on: 1'b1};
      motor_reg <= '{level: 6'h00, brake: 1'b1, nmos_on: 1'b1, pmos_on: 1'b0};
      applied_reg <= '0;
      request_reg <= '0;
      ramp_cnt_reg <= 8'h00;
    end else begin
      lin_a_reg <= lin_a_next;
      lin_b_reg <= lin_b_next;
      vib_reg <= vib_next;
      dvs_one_reg <= dvs_one_next;
      dvs_two_reg <= dvs_two_next;
      pins_last_reg <= pins_last_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      a_out_reg <= a_out_next;
      b_out_reg <= b_out_next;
      motor_reg <= motor_next;
      applied_reg <= applied_next;
      request_reg <= request_next;
      ramp_cnt_reg <= ramp_cnt_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign reg_a_ctl = a_out_reg;
  assign reg_b_ctl = b_out_reg;
  assign motor = motor_reg;
  assign ramp_choice = applied_reg;
  assign ramp_request = request_reg;

endmodule

// file: sim/rvs_regs_asserts.sv
// Port checks for the regulator select bank.
`timescale 1ns/1ps
module rvs_regs_asserts
  import rvs_pkg::*;
(
  // Watched ports.
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rvs_lin_out_t reg_a_ctl,
  input wire rvs_motor_t motor,
  input wire logic [NUM_RAMP-1:0] ramp_choice,
  input wire logic [NUM_RAMP-1:0] ramp_request
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic take = psel && penable && !pready;
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_answer_time: assert property (take |=> pready)
    else $error("no answer after take");
  a_misalign_err: assert property (take && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  a_brake_zero: assert property (motor.level == 6'h00 |-> motor.brake && motor.nmos_on)
    else $error("zero level without brake");
  a_drive_level: assert property (take && pwrite && paddr == 12'h0c4 |=>
    motor.level == $past(pwdata[5:0]) && !motor.pmos_on) else $error("motor level wrong");
  a_pulldown_gone: assert property (reg_a_ctl.on |-> !reg_a_ctl.pulldown_on)
    else $error("pull-down on while enabled");
  a_ramp_holds: assert property ($rose(ramp_request[0]) |-> ramp_request[0] [*8])
    else $error("ramp request dropped early");
  a_choice_ramped: assert property ($changed(ramp_choice) |-> $past(ramp_request) != 0)
    else $error("choice moved without request");
endmodule
bind rvs_regs rvs_regs_asserts i_chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .reg_a_ctl(reg_a_ctl), .motor(motor), .ramp_choice(ramp_choice),
  .ramp_request(ramp_request));

// file: sim/rvs_pin_model.sv
// Model of the sequencer and GPIO pins feeding the bank.
`timescale 1ns/1ps
module rvs_pin_model (
  // Clock, reset and wanted levels.
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] want,
  // Levels seen by the bank.
  output logic seq_apply,
  output logic gpio_one,
  output logic gpio_two,
  output logic general_pin_thirteen
);
  // Pins move just after an edge, so the bank never samples a change mid-cycle.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {general_pin_thirteen, gpio_two, gpio_one, seq_apply} <= 4'h0;
    end else begin
      {general_pin_thirteen, gpio_two, gpio_one, seq_apply} <= want;
    end
  end
endmodule

// file: sim/rvs_regs_bench.sv
// Self-checking bench for the regulator select bank.
`timescale 1ns/1ps
module rvs_regs_bench
  import rvs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, seq_apply, gpio_one, gpio_two, general_pin_thirteen;
  logic [3:0] want = 4'h0;
  rvs_lin_out_t reg_a_ctl, reg_b_ctl;
  rvs_motor_t motor;
  logic [NUM_RAMP-1:0] ramp_choice, ramp_request;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // Unit under test and the pin source.
  rvs_regs i_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seq_apply(seq_apply), .gpio_one(gpio_one), .gpio_two(gpio_two),
    .general_pin_thirteen(general_pin_thirteen), .reg_a_ctl(reg_a_ctl),
    .reg_b_ctl(reg_b_ctl), .motor(motor), .ramp_choice(ramp_choice),
    .ramp_request(ramp_request));
  rvs_pin_model i_pins (.ref_clk(ref_clk), .rstn(rstn), .want(want), .seq_apply(seq_apply),
    .gpio_one(gpio_one), .gpio_two(gpio_two), .general_pin_thirteen(general_pin_thirteen));
  // Clock and a hang guard well above the expected run.
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // One APB transfer; the wait ends on pready, never on a fixed count.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_rst();
    logic [7:0] ix [5] = '{IDX_LIN_A, IDX_LIN_B, IDX_VIB, IDX_DVS_ONE, IDX_DVS_TWO};
    foreach (ix[i]) begin
      apb(1'b0, ad(ix[i]), 8'h00);
      chk("reset value", 32'h0, rd);
    end
    chk("reset ctl", 32'(3'b001), 32'(reg_a_ctl));
    $display("test reset done");
  endtask
  task automatic t_lin();
    apb(1'b1, ad(IDX_LIN_A), 8'h19);
    chk("a ctl", 32'(3'b110), 32'(reg_a_ctl));
    apb(1'b1, ad(IDX_LIN_B), 8'h08);
    chk("b ctl", 32'(3'b000), 32'(reg_b_ctl));
    apb(1'b0, ad(IDX_LIN_A), 8'h00);
    chk("a readback", 32'h19, rd);
    apb(1'b1, 12'h0bd, 8'hff);
    chk("misaligned", 32'h1, 32'(er));
    apb(1'b0, ad(8'h34), 8'h00);
    chk("unmapped", 32'h1, 32'(er));
    apb(1'b0, ad(IDX_LIN_A), 8'h00);
    chk("a kept", 32'h19, rd);
    $display("test control done");
  endtask
  task automatic t_gpio();
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, ad(IDX_LIN_A), 8'((s << 5) | (s << 1)));
      want <= 4'(1 << s);
      repeat (4) @(posedge ref_clk);
      chk("gpio rise", 32'(3'b100), 32'(reg_a_ctl));
      want <= 4'h0;
      repeat (4) @(posedge ref_clk);
      chk("gpio fall", 32'(3'b011), 32'(reg_a_ctl));
    end
    apb(1'b1, ad(IDX_LIN_A), 8'h80);
    want <= 4'h1;
    repeat (4) @(posedge ref_clk);
    chk("seq target", 32'(3'b100), 32'(reg_a_ctl));
    want <= 4'h0;
    $display("test pins done");
  endtask
  task automatic t_vib();
    apb(1'b1, ad(IDX_VIB), 8'hff);
    chk("motor full", 32'({6'h3f, 3'b000}), 32'(motor));
    apb(1'b0, ad(IDX_VIB), 8'h00);
    chk("vib readback", 32'(MASK_VIB), rd);
    apb(1'b1, ad(IDX_VIB), 8'h01);
    chk("motor step", 32'({6'h01, 3'b000}), 32'(motor));
    apb(1'b1, ad(IDX_VIB), 8'hc0);
    chk("motor brake", 32'({6'h00, 3'b110}), 32'(motor));
    $display("test motor done");
  endtask
  task automatic t_dvs();
    int n;
    n = 0;
    apb(1'b1, ad(IDX_DVS_ONE), 8'ha5);
    apb(1'b1, ad(IDX_DVS_TWO), 8'hff);
    apb(1'b0, ad(IDX_DVS_TWO), 8'h00);
    chk("dvs two readback", 32'(MASK_DVS_TWO), rd);
    chk("ramp busy", 32'h3a5, 32'(ramp_request));
    chk("ramp start", 32'h0, 32'(ramp_choice));
    while (ramp_request !== 10'h000 && n++ < 300) @(posedge ref_clk);
    // The read returns five edges after the last write lands; the ramp restarts a cycle past it.
    chk("ramp cycles", 32'(RAMP_CYCLES - 3), 32'(n));
    chk("ramp end", 32'h3a5, 32'(ramp_choice));
    $display("test ramp done");
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_rst();
    t_lin();
    t_gpio();
    t_vib();
    t_dvs();
    close_out();
  end
endmodule
